// ===== design/acr_pkg.sv
// constants, register map and types for the async receive front end
package acr_pkg;
  // sample counts per bit
  localparam int unsigned SAMPLES_NORMAL = 16;
  localparam int unsigned SAMPLES_DOUBLE = 8;
  // first voting sample (middle is first+1, last is first+2)
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // control bit positions
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_DOUBLE = 1;
  localparam int unsigned CTRL_PAR_EN = 2;
  localparam int unsigned CTRL_PAR_ODD = 3;
  localparam int unsigned CTRL_LEN_LSB = 4;
  localparam logic [3:0] CTRL_LEN_RESET = 4'h8;
  // data register bit positions
  localparam int unsigned DATA_FE = 9;
  localparam int unsigned DATA_PE = 10;
  localparam int unsigned DATA_VALID = 11;
  // interrupt status bits
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_FRAME_ERR = 1;
  localparam int unsigned IRQ_PAR_ERR = 2;
  localparam int unsigned IRQ_NOISE = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11,
    ST_STOP = 2'b10
  } acr_state_t;

  // received character with its status, stored together
  typedef struct packed {
    logic valid;
    logic parity_error_flag;
    logic frame_error_flag;
    logic [8:0] data;
  } acr_char_t;
endpackage

// ===== design/acr_rx.sv
// async receive clock and data recovery with AXI4-Lite registers
`timescale 1ns/10ps
module acr_rx
  import acr_pkg::*;
#(
  parameter int unsigned DIV_W = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // serial line
  input wire logic i_serial_rx_line,
  // axi4-lite write
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // interrupt
  output logic o_irq
);
  logic [7:0] ctrl;
  logic [DIV_W-1:0] baud_divisor_value;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  acr_char_t rx_char;
  logic enable;
  logic double_speed_select;
  logic parity_enable_bit;
  logic parity_odd_select;
  logic [3:0] data_len;
  assign enable = ctrl[CTRL_ENABLE];
  assign double_speed_select = ctrl[CTRL_DOUBLE];
  assign parity_enable_bit = ctrl[CTRL_PAR_EN];
  assign parity_odd_select = ctrl[CTRL_PAR_ODD];
  assign data_len = ctrl[CTRL_LEN_LSB +: 4];

  // sample tick: divisor+1 core clocks per sample
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  assign tick = enable && (div_cnt == '0);
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !enable) begin
      div_cnt <= '0;
    end else if (div_cnt == '0) begin
      div_cnt <= baud_divisor_value;
    end else begin
      div_cnt <= div_cnt - DIV_W'(1);
    end
  end

  // synchroniser; only sync2 is read by logic
  logic sync1;
  logic sync2;
  logic prev_line;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= i_serial_rx_line;
      sync2 <= sync1;
    end
  end

  // recovery state machine
  acr_state_t state;
  logic [4:0] samp;
  logic [3:0] bit_idx;
  logic [2:0] votes;
  logic [8:0] shreg;
  logic par_bit;
  logic [4:0] samples_per_bit;
  logic [4:0] vote_first;
  logic [4:0] vote_last;
  logic voted;
  logic [3:0] frame_bits;
  logic par_ok;
  assign samples_per_bit = double_speed_select ? 5'(SAMPLES_DOUBLE)
                                               : 5'(SAMPLES_NORMAL);
  assign vote_first = double_speed_select ? VOTE_FIRST_DOUBLE
                                          : VOTE_FIRST_NORMAL;
  assign vote_last = vote_first + 5'h02;
  // majority of three, counting the current sample
  assign voted = (votes[0] & votes[1]) | (votes[0] & sync2) |
                 (votes[1] & sync2);
  assign frame_bits = data_len + {3'h0, parity_enable_bit};
  assign par_ok = ((^shreg) ^ par_bit ^ parity_odd_select) == 1'b0;

  logic done_pulse;
  logic noise_pulse;
  always_ff @(posedge i_core_clk) begin
    done_pulse <= 1'b0;
    noise_pulse <= 1'b0;
    if (i_rst || !enable) begin
      state <= ST_IDLE;
      samp <= 5'h00;
      bit_idx <= 4'h0;
      votes <= 3'h0;
      shreg <= 9'h000;
      par_bit <= 1'b0;
      prev_line <= 1'b1;
    end else if (tick) begin
      prev_line <= sync2;
      if (samp >= vote_first && samp < vote_last) begin
        votes <= {votes[1:0], sync2};
      end
      case (state)
        ST_IDLE: begin
          if (prev_line && !sync2) begin
            state <= ST_START;
            samp <= 5'h02;
            // short characters must not inherit high bits or parity
            shreg <= 9'h000;
            votes <= 3'h0;
          end
        end
        ST_START: begin
          samp <= samp + 5'h01;
          if (samp == vote_last) begin
            if (voted) begin
              state <= ST_IDLE;
              noise_pulse <= 1'b1;
            end else begin
              state <= ST_DATA;
              bit_idx <= 4'h0;
            end
          end
        end
        ST_DATA: begin
          // counter wraps each bit period, phase set by the start bit
          samp <= (samp == samples_per_bit) ? 5'h01
                                            : samp + 5'h01;
          if (samp == vote_last) begin
            if (bit_idx < data_len) begin
              shreg[bit_idx] <= voted;
            end else begin
              par_bit <= voted;
            end
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx + 4'h1 == frame_bits) begin
              state <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          samp <= (samp == samples_per_bit) ? 5'h01 : samp + 5'h01;
          if (samp == vote_last) begin
            // back to idle at once: early next start, extra stops ignored
            // edge detect keeps tracking, so a low stop fakes no start
            state <= ST_IDLE;
            done_pulse <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // character capture, status stored alongside
  logic stop_val;
  logic data_read;
  assign stop_val = voted;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !enable) begin
      rx_char <= '0;
    end else if (tick && state == ST_STOP && samp == vote_last) begin
      rx_char.valid <= 1'b1;
      rx_char.data <= shreg;
      rx_char.frame_error_flag <= !stop_val;
      rx_char.parity_error_flag <= parity_enable_bit && !par_ok;
    end else if (data_read) begin
      rx_char.valid <= 1'b0;
    end
  end

  // event flags: set wins over write-one clear
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  always_comb begin
    ev = '0;
    ev[IRQ_DONE] = done_pulse;
    ev[IRQ_FRAME_ERR] = done_pulse && rx_char.frame_error_flag;
    ev[IRQ_PAR_ERR] = done_pulse && rx_char.parity_error_flag;
    ev[IRQ_NOISE] = noise_pulse;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
    end
  end
  assign o_irq = |(irq_stat & irq_mask);

  // axi4-lite write: take address and data in either order
  logic aw_held;
  logic w_held;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic do_write;
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign do_write = aw_held && w_held && !o_bvalid;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        wdata_q <= i_wdata;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (awaddr_q == OFS_CTRL || awaddr_q == OFS_DIV ||
                    awaddr_q == OFS_IRQ_STAT || awaddr_q == OFS_IRQ_MASK)
                   ? RESP_OKAY : RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  assign clr = (do_write && awaddr_q == OFS_IRQ_STAT)
               ? wdata_q[IRQ_W-1:0] : '0;
  // byte strobes ignored: every register fits the low lane pair
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl <= {CTRL_LEN_RESET, 4'h0};
      baud_divisor_value <= DIV_W'(DIV_RESET);
      irq_mask <= '0;
    end else if (do_write) begin
      case (awaddr_q)
        OFS_CTRL: ctrl <= wdata_q[7:0];
        OFS_DIV: baud_divisor_value <= wdata_q[DIV_W-1:0];
        OFS_IRQ_MASK: irq_mask <= wdata_q[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // axi4-lite read: one cycle after address taken
  assign o_arready = !o_rvalid;
  assign data_read = i_arvalid && o_arready && i_araddr == OFS_DATA;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp <= RESP_OKAY;
      case (i_araddr)
        OFS_CTRL: o_rdata <= {24'h00_0000, ctrl};
        OFS_DIV: o_rdata <= 32'(baud_divisor_value);
        OFS_DATA: o_rdata <= 32'(rx_char);
        OFS_IRQ_STAT: o_rdata <= 32'(irq_stat);
        OFS_IRQ_MASK: o_rdata <= 32'(irq_mask);
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule

// ===== verif/acr_rx_checker.sv
// bus and interrupt assertions for the async receive front end
`timescale 1ns/10ps
module acr_rx_checker
  import acr_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // interrupt
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr_both;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_b_late;
    ##1 o_bvalid;
  endsequence
  chk_b_answer: assert property (s_wr_both |=> s_b_late)
    else $error("write answer missing");
  chk_b_hold: assert property (o_bvalid && !i_bready
    |=> o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
  chk_r_hold: assert property (o_rvalid && !i_rready
    |=> o_rvalid && $stable(o_rdata)) else $error("rdata dropped");
  chk_aw_refuse: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answering");
  chk_ar_refuse: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while answering");
  chk_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_r_unmapped: assert property (i_arvalid && o_arready &&
    i_araddr > OFS_IRQ_MASK |=> o_rresp == RESP_SLVERR && o_rdata == '0)
    else $error("unmapped read not refused");
  chk_irq_reset: assert property ($past(i_rst) |-> !o_irq)
    else $error("irq high after reset");
endmodule
bind acr_rx acr_rx_checker u_chk (.i_core_clk, .i_rst, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
  .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
  .i_rready, .o_irq);

// ===== verif/acr_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/10ps
module acr_tx_model (
  // clock
  input wire logic i_clk,
  // serial line, idle high
  output logic o_line
);
  initial o_line = 1'b1;
  // whole clock counts per bit keep the rate error at zero
  task automatic hold(input logic v, input int c);
    o_line <= v;
    repeat (c) @(posedge i_clk);
  endtask
  task automatic send(input logic [10:0] b, input int n, sp, stp);
    hold(1'b0, sp);
    for (int i = 0; i < n; i++) hold(b[i], sp);
    hold(b[n], stp);
  endtask
endmodule

// ===== verif/acr_rx_test.sv
// self-checking bench for the async receive front end
`timescale 1ns/10ps
module acr_rx_test
  import acr_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, line;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  int err_total = 0, tests_run = 0;
  always #50 clk = ~clk;
  acr_rx u_dut (.i_core_clk(clk), .i_rst(rst), .i_serial_rx_line(line),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .o_irq(irq));
  acr_tx_model u_tx (.i_clk(clk), .o_line(line));
  task automatic test_done;
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bound(input bit ok);
    if (!ok) begin
      err_total++;
      test_done;
    end
  endtask
  // readiness sampled mid-cycle, acted on at the following edge;
  // ready comes a cycle late so every answer must stand meanwhile
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw, w, b, fin;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 99 && !fin; n++) begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      fin = b & bready;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= !fin;
      if (fin) cmp({30'h0, bresp}, {30'h0, er});
    end
    bound(fin);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bit ar, rv, fin;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 99 && !fin; n++) begin
      @(negedge clk);
      ar = arvalid & arready;
      rv = rvalid;
      fin = rv & rready;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= !fin;
      if (fin) cmp(rdata, e);
      if (fin) cmp({30'h0, rresp}, {30'h0, er});
    end
    bound(fin);
  endtask
  task automatic t_regs;
    rd(OFS_CTRL, 32'h80, RESP_OKAY);
    rd(OFS_DIV, 32'h0, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    $display("register test ended");
  endtask
  task automatic t_frame(input bit dbl, pe, odd, bad, fe,
                         input int len, div, input logic [8:0] d);
    logic [10:0] b;
    int n;
    int sp;
    b = {2'b00, d};
    n = len;
    sp = (dbl ? 8 : 16) * (div + 1);
    if (pe) begin
      b[n] = ^d ^ odd ^ bad;
      n++;
    end
    b[n] = !fe;
    wr(OFS_DIV, 32'(div), RESP_OKAY);
    wr(OFS_CTRL, 32'({4'(len), odd, pe, dbl, 1'b1}), RESP_OKAY);
    u_tx.send(b, n, sp, sp);
    u_tx.hold(1'b1, sp);
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge clk);
    bound(irq === 1'b1);
    rd(OFS_IRQ_STAT, 32'({bad & pe, fe, 1'b1}), RESP_OKAY);
    rd(OFS_DATA, 32'({1'b1, bad & pe, fe, d}), RESP_OKAY);
    rd(OFS_DATA, 32'({1'b0, bad & pe, fe, d}), RESP_OKAY);
    wr(OFS_IRQ_STAT, 32'hf, RESP_OKAY);
    rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
    $display("frame test ended");
  endtask
  task automatic t_b2b;
    wr(OFS_CTRL, 32'h81, RESP_OKAY);
    u_tx.send(11'h13c, 8, 16, 11);
    u_tx.send(11'h1c3, 8, 16, 16);
    u_tx.hold(1'b1, 16);
    rd(OFS_DATA, 32'h8c3, RESP_OKAY);
    rd(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
    wr(OFS_IRQ_STAT, 32'hf, RESP_OKAY);
    $display("back to back test ended");
  endtask
  task automatic t_noise;
    wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    u_tx.hold(1'b0, 5);
    u_tx.hold(1'b1, 40);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STAT, 32'h8, RESP_OKAY);
    rd(OFS_DATA, 32'h0c3, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h8, RESP_OKAY);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h8, RESP_OKAY);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h0);
    $display("noise test ended");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    wr(OFS_IRQ_MASK, 32'hf, RESP_OKAY);
    t_frame(0, 0, 0, 0, 0, 8, 0, 9'h0a5);
    t_frame(1, 1, 0, 0, 0, 7, 1, 9'h05a);
    t_frame(0, 1, 1, 1, 0, 9, 0, 9'h1c3);
    t_frame(1, 0, 0, 0, 1, 5, 0, 9'h013);
    t_b2b;
    t_noise;
    test_done;
  end
endmodule
